// file: plb_bank_gate.sv
// One output bank: drives, parks low at falling edges, or floats
// Assumes clkIn comes from flops on clk
`timescale 1ns/100ps
module plb_bank_gate #(
    parameter int WIDTH = 4
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             reset_n,
    // Control
    input  wire logic [WIDTH-1:0] clkIn,
    input  wire logic             bankOff,
    input  wire logic             hiZMode,
    input  wire logic             forceHiZ,
    // Pins
    output logic [WIDTH-1:0]      q,
    output logic [WIDTH-1:0]      qOe_n
);
    import plb_pkg::*;

    logic [WIDTH-1:0] parked_r;
    logic             parkReq;

    assign parkReq = bankOff && !hiZMode;

    // Park and unpark only while the clock is low
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            parked_r <= '0;
            q        <= '0;
        end else begin
            parked_r <= (parked_r & clkIn) | ({WIDTH{parkReq}} & ~clkIn);
            q        <= clkIn & ~parked_r;
        end
    end

    assign qOe_n = {WIDTH{forceHiZ || (bankOff && hiZMode)}};

    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);

    hiz_now_a: assert property (bankOff && hiZMode |-> &qOe_n) else $error("bank not floating");
    drive_on_a: assert property (!bankOff && !forceHiZ |-> qOe_n == '0) else $error("bank not driven");
    park_bound_a: assert property ((parkReq && !clkIn[0]) ##1 parkReq[*6] |-> !q[0])
        else $error("bank not parked");
    no_runt_a: assert property ($fell(q[0]) |-> !$past(clkIn[0])) else $error("shortened pulse");
endmodule : plb_bank_gate

// file: plb_board_model.sv
// Board model: reference and PLL clocks plus a feedback loop stand-in
// Assumes clk is the 200 MHz system clock; ref period is 16 clk cycles
`timescale 1ns/100ps
module plb_board_model (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       reset_n,
    // Feedback control
    input  wire logic [3:0] fbOffset,
    input  wire logic       fbOn,
    // Clocks
    output logic            refLevel,
    output logic            pllLevel,
    output logic            fbLevel
);
    logic [3:0] phase_r;
    logic [3:0] fbPhase;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            phase_r <= 4'h0;
        end else begin
            phase_r <= phase_r + 4'h1;
        end
    end

    // Reference never stops, so the lock flag stays meaningful
    assign refLevel = ~phase_r[3];
    assign pllLevel = refLevel;
    assign fbPhase  = phase_r - fbOffset;
    // A removed feedback clock rests low
    assign fbLevel  = fbOn & ~fbPhase[3];
endmodule : plb_board_model

// file: plb_clock_control.sv
// Top of the PLL buffer control: pin sync, test mode, skew, gating, lock
// Assumes asynchronous board pins and static configuration selects
//
// Notes on behaviour
// - each bank has its own disable
// - enabled bank toggles in high or low mode
// - high mode disable floats bank at once
// - low mode disable parks within six cycles
// - outputs park low only at falling edges
// - mid mode means factory test mode
// - phase error beyond limit is flagged
// - four consecutive errors drop lock
// - thirty-two clean cycles raise lock
// - watchdog on divided reference drops lock
// - lock meaningful only with reference toggling
// - test mode uses reference in place of PLL
// - test mode forces feedback input low
// - test mode keeps dividers, skew, lock running
// - mode passing mid briefly enters test mode
// - bank two disable in test resets machines
// - reset state depends on selections
// - held until bank two disable released
// - bank two can follow bank one skew
// - mid/low and mid/high pick bank one pairs
`timescale 1ns/100ps
module plb_clock_control #(
    parameter int CNT_W      = plb_pkg::LOCK_CNT_W,
    parameter int WDOG_DIV   = plb_pkg::WDOG_DIV_DEF,
    parameter int WDOG_TICKS = plb_pkg::WDOG_TICKS_DEF
) (
    // Clock and reset
    input  wire logic                      clk,
    input  wire logic                      reset_n,
    // Board pins
    input  wire plb_pkg::plb_pins_t        pins,
    // Bank one
    output logic [plb_pkg::BANK_ONE_W-1:0] bankOneOutputs,
    output logic [plb_pkg::BANK_ONE_W-1:0] bankOneOe_n,
    // Bank two
    output logic [plb_pkg::BANK_TWO_W-1:0] bankTwoOutputs,
    output logic [plb_pkg::BANK_TWO_W-1:0] bankTwoOe_n,
    // Feedback and lock
    output logic                           feedbackOutput,
    output logic                           lock
);
    import plb_pkg::*;

    localparam int PRE_W  = $clog2(WDOG_DIV);
    localparam int TICK_W = $clog2(WDOG_TICKS + 1);

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers and edge detection

    plb_pins_t pinsMeta_r;
    plb_pins_t pins_r;
    logic      refPrev_r;
    logic      srcPrev_r;
    logic      fdbkPrev_r;
    logic      testMode;
    logic      srcLevel;
    logic      fdbkLevel;
    logic      refRise;
    logic      srcRise;
    logic      fdbkRise;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pinsMeta_r <= '0;
            pins_r     <= '0;
        end else begin
            pinsMeta_r <= pins;
            pins_r     <= pinsMeta_r;
        end
    end

    // No filtering on mode, so a pass through mid is seen
    assign testMode  = (pins_r.mode == TRI_MID);
    assign srcLevel  = testMode ? pins_r.refLevel : pins_r.pllLevel;
    assign fdbkLevel = testMode ? 1'b0 : pins_r.feedbackClockPin;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            refPrev_r  <= 1'b0;
            srcPrev_r  <= 1'b0;
            fdbkPrev_r <= 1'b0;
        end else begin
            refPrev_r  <= pins_r.refLevel;
            srcPrev_r  <= srcLevel;
            fdbkPrev_r <= fdbkLevel;
        end
    end

    assign refRise  = pins_r.refLevel && !refPrev_r;
    assign srcRise  = srcLevel && !srcPrev_r;
    assign fdbkRise = fdbkLevel && !fdbkPrev_r;

    ////////////////////////////////////////////////////////////////////////
    // Deterministic reset sequence in test mode

    plb_test_t state_r;
    plb_test_t state_nxt;
    logic      holdReq;
    logic      holdFsm;
    logic [2:0] edgeCnt_r;

    assign holdReq = testMode && pins_r.bankDisable[1];
    assign holdFsm = (state_r == TST_HELD);

    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            TST_RUN: begin
                if (holdReq) begin
                    state_nxt = TST_COUNT;
                end
            end
            TST_COUNT: begin
                if (!holdReq) begin
                    state_nxt = TST_RUN;
                end else if (refRise && edgeCnt_r == 3'(TEST_EDGES - 1)) begin
                    state_nxt = TST_HELD;
                end
            end
            TST_HELD: begin
                if (!holdReq) begin
                    state_nxt = TST_RUN;
                end
            end
            default: begin
                state_nxt = TST_RUN;
            end
        endcase
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_r <= TST_RUN;
        end else begin
            state_r <= state_nxt;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            edgeCnt_r <= '0;
        end else if (state_r != TST_COUNT) begin
            edgeCnt_r <= '0;
        end else if (refRise) begin
            edgeCnt_r <= edgeCnt_r + 3'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Skew taps and output paths
    // Groups: 0 bank one pair A, 1 bank one pair B, 2 bank two, 3 feedback

    logic [TAP_W-1:0]       tap [SKEW_GROUPS];
    logic [3:0]             ratio [SKEW_GROUPS];
    logic [3:0]             preset [SKEW_GROUPS];
    logic [SKEW_GROUPS-1:0] grpClk;
    logic [3:0]             bankTwoIdx;
    logic [1:0]             freqVal;

    assign bankTwoIdx = plb_pair_idx(pins_r.bankTwoPhaseSelect[1], pins_r.bankTwoPhaseSelect[0]);
    assign freqVal    = plb_tri_val(pins_r.freqSelect);

    assign tap[0] = SKEW_ONE_BASE + {1'b0, plb_pair_idx(pins_r.bankOnePhaseSelect[1],
                                                        pins_r.bankOnePhaseSelect[0])};
    assign tap[1] = SKEW_ONE_BASE + {1'b0, plb_pair_idx(pins_r.bankOnePhaseSelect[3],
                                                        pins_r.bankOnePhaseSelect[2])};
    assign tap[3] = SKEW_FB_STEP * {3'h0, plb_tri_val(pins_r.fdbkPhaseSelect)} + SKEW_FB_STEP;

    always_comb begin
        if (bankTwoIdx == BK2_FOLLOW_A) begin
            tap[2] = tap[0];
        end else if (bankTwoIdx == BK2_FOLLOW_B) begin
            tap[2] = tap[1];
        end else if (bankTwoIdx == BK2_ZERO) begin
            tap[2] = SKEW_ZERO_TAP;
        end else if (bankTwoIdx < BK2_FOLLOW_A) begin
            tap[2] = {1'b0, bankTwoIdx};
        end else begin
            tap[2] = {1'b0, bankTwoIdx} + SKEW_ZERO_TAP;
        end
    end

    // Dividers keep running in test mode; only hold stops them
    for (genvar g = 0; g < SKEW_GROUPS; g++) begin : g_path
        localparam int DSEL = (g < 2) ? 0 : g - 1;
        logic [3:0] presetRaw;

        assign ratio[g]  = plb_div_ratio(plb_pair_idx(pins_r.divSelect[DSEL][1],
                                                      pins_r.divSelect[DSEL][0]));
        assign presetRaw = {2'h0, freqVal} + {2'h0, tap[g][1:0]};
        assign preset[g] = (presetRaw < ratio[g]) ? presetRaw : 4'h0;

        plb_skew_path u_path (
            .clk      (clk),
            .reset_n  (reset_n),
            .srcLevel (srcLevel),
            .srcRise  (srcRise),
            .hold     (holdFsm),
            .ratio    (ratio[g]),
            .preset   (preset[g]),
            .tap      (tap[g]),
            .pathClk  (grpClk[g])
        );
    end

    assign feedbackOutput = grpClk[3];

    ////////////////////////////////////////////////////////////////////////
    // Bank gating

    logic [1:0] bankOff;
    logic       hiZMode;

    assign bankOff = pins_r.bankDisable & {2{!testMode}};
    assign hiZMode = (pins_r.mode == TRI_HIGH);

    plb_bank_gate #(
        .WIDTH (BANK_ONE_W)
    ) u_bank_one (
        .clk      (clk),
        .reset_n  (reset_n),
        .clkIn    ({grpClk[1], grpClk[1], grpClk[0], grpClk[0]}),
        .bankOff  (bankOff[0]),
        .hiZMode  (hiZMode),
        .forceHiZ (holdReq),
        .q        (bankOneOutputs),
        .qOe_n    (bankOneOe_n)
    );

    plb_bank_gate #(
        .WIDTH (BANK_TWO_W)
    ) u_bank_two (
        .clk      (clk),
        .reset_n  (reset_n),
        .clkIn    ({BANK_TWO_W{grpClk[2]}}),
        .bankOff  (bankOff[1]),
        .hiZMode  (hiZMode),
        .forceHiZ (holdReq),
        .q        (bankTwoOutputs),
        .qOe_n    (bankTwoOe_n)
    );

    ////////////////////////////////////////////////////////////////////////
    // Lock detector
    // Without reference edges the watchdog cannot advance, so lock may be stale

    logic [CNT_W-1:0]  sinceRef_r;
    logic [CNT_W-1:0]  refPeriod_r;
    logic [2:0]        errCnt_r;
    logic [5:0]        goodCnt_r;
    logic [PRE_W-1:0]  wdPre_r;
    logic [TICK_W-1:0] wdTicks_r;
    logic              phaseErr;
    logic              wdTick;
    logic              wdExpire;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            sinceRef_r  <= '0;
            refPeriod_r <= '0;
        end else if (refRise) begin
            sinceRef_r  <= '0;
            refPeriod_r <= sinceRef_r;
        end else if (!(&sinceRef_r)) begin
            sinceRef_r <= sinceRef_r + 1'b1;
        end
    end

    // Error when the offset is beyond the limit on both sides of the reference
    assign phaseErr = (sinceRef_r > CNT_W'(PHASE_ERROR_LIMIT_CYC)) &&
                      ((refPeriod_r - sinceRef_r) > CNT_W'(PHASE_ERROR_LIMIT_CYC));

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            errCnt_r <= '0;
        end else if (fdbkRise) begin
            if (!phaseErr) begin
                errCnt_r <= '0;
            end else if (errCnt_r < 3'(LOCK_ERR_CYCLES)) begin
                errCnt_r <= errCnt_r + 3'h1;
            end
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            goodCnt_r <= '0;
        end else if (wdExpire || (fdbkRise && phaseErr)) begin
            goodCnt_r <= '0;
        end else if (fdbkRise && goodCnt_r < 6'(LOCK_GOOD_CYCLES)) begin
            goodCnt_r <= goodCnt_r + 6'h01;
        end
    end

    // Watchdog counts divided reference ticks since the last feedback edge
    assign wdTick   = refRise && (wdPre_r == PRE_W'(WDOG_DIV - 1));
    assign wdExpire = wdTick && !fdbkRise && (wdTicks_r == TICK_W'(WDOG_TICKS - 1));

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            wdPre_r <= '0;
        end else if (refRise) begin
            wdPre_r <= wdPre_r + 1'b1;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            wdTicks_r <= '0;
        end else if (fdbkRise) begin
            wdTicks_r <= '0;
        end else if (wdTick && wdTicks_r != TICK_W'(WDOG_TICKS - 1)) begin
            wdTicks_r <= wdTicks_r + 1'b1;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            lock <= 1'b0;
        end else if (wdExpire) begin
            lock <= 1'b0;
        end else if (fdbkRise) begin
            if (lock && phaseErr && errCnt_r >= 3'(LOCK_ERR_CYCLES - 1)) begin
                lock <= 1'b0;
            end else if (!lock && !phaseErr && goodCnt_r == 6'(LOCK_GOOD_CYCLES - 1)) begin
                lock <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);

    sequence s_fifth_edge;
        state_r == TST_COUNT && holdReq && refRise && edgeCnt_r == 3'(TEST_EDGES - 1);
    endsequence

    sequence s_held_pair;
        holdFsm ##1 holdFsm;
    endsequence

    test_enter_a: assert property (pins_r.mode == TRI_MID && !pins_r.bankDisable[1]
                                   |-> bankOneOe_n == '0 && bankTwoOe_n == '0)
        else $error("test mode not entered");
    ref_bypass_a: assert property (testMode |=> srcPrev_r == $past(pins_r.refLevel))
        else $error("reference not bypassed");
    fdbk_low_a: assert property (testMode ##1 testMode |-> !fdbkPrev_r)
        else $error("feedback not low in test");
    all_float_a: assert property (holdReq |-> &bankOneOe_n && &bankTwoOe_n)
        else $error("outputs driven in test hold");
    fsm_held_a: assert property (s_fifth_edge |=> holdFsm)
        else $error("hold not reached after edges");
    held_quiet_a: assert property (s_held_pair |-> grpClk == '0)
        else $error("outputs moved while held");
    hold_release_a: assert property (holdFsm && !holdReq |=> state_r == TST_RUN)
        else $error("hold not released");
    follow_one_a: assert property ((bankTwoIdx == BK2_FOLLOW_A |-> tap[2] == tap[0])
                                   and (bankTwoIdx == BK2_FOLLOW_B |-> tap[2] == tap[1]))
        else $error("bank two not following");
    err_count_a: assert property (fdbkRise && phaseErr && errCnt_r == 3'h0 |=> errCnt_r == 3'h1)
        else $error("phase error not counted");
    lock_drop_a: assert property (lock && fdbkRise && phaseErr && errCnt_r == 3'(LOCK_ERR_CYCLES - 1)
                                  |=> !lock) else $error("lock not dropped");
    lock_rise_a: assert property ($rose(lock) |-> $past(goodCnt_r) == 6'(LOCK_GOOD_CYCLES - 1))
        else $error("lock rose early");
    wdog_drop_a: assert property (wdExpire |=> !lock && goodCnt_r == '0)
        else $error("watchdog did not drop lock");
    good_clear_a: assert property (fdbkRise && !phaseErr |=> errCnt_r == '0)
        else $error("error count not cleared");
endmodule : plb_clock_control

// file: plb_pkg.sv
// Shared types, constants and lookup functions for the PLL buffer control
// Assumes a 200 MHz system clock; three-level pins arrive pre-encoded
package plb_pkg;

    // Three-level pin code: low, mid, high
    typedef logic [1:0] plb_tri_t;
    localparam plb_tri_t TRI_LOW  = 2'h0;
    localparam plb_tri_t TRI_MID  = 2'h1;
    localparam plb_tri_t TRI_HIGH = 2'h3;

    // Board pins as seen by the block
    typedef struct packed {
        plb_tri_t             mode;
        logic [1:0]           bankDisable;
        logic                 refLevel;
        logic                 pllLevel;
        logic                 feedbackClockPin;
        plb_tri_t [3:0]       bankOnePhaseSelect;
        plb_tri_t [1:0]       bankTwoPhaseSelect;
        plb_tri_t             fdbkPhaseSelect;
        plb_tri_t [2:0][1:0]  divSelect;
        plb_tri_t             freqSelect;
    } plb_pins_t;

    typedef enum logic [1:0] {
        TST_RUN   = 2'h0,
        TST_COUNT = 2'h1,
        TST_HELD  = 2'h3
    } plb_test_t;

    localparam int BANK_ONE_W  = 4;
    localparam int BANK_TWO_W  = 6;
    localparam int SKEW_GROUPS = 4;
    localparam int SKEW_TAPS   = 17;
    localparam int TAP_W       = 5;

    localparam logic [4:0] SKEW_ONE_BASE = 5'h04;
    localparam logic [4:0] SKEW_ZERO_TAP = 5'h08;
    localparam logic [4:0] SKEW_FB_STEP  = 5'h04;
    localparam logic [3:0] BK2_FOLLOW_A  = 4'h3;
    localparam logic [3:0] BK2_FOLLOW_B  = 4'h5;
    localparam logic [3:0] BK2_ZERO      = 4'h4;

    localparam int CLK_PERIOD_PS         = 5000;
    localparam int PHASE_ERROR_LIMIT_PS  = 10000;
    localparam int PHASE_ERROR_LIMIT_CYC = (PHASE_ERROR_LIMIT_PS / CLK_PERIOD_PS < 1) ?
                                           1 : PHASE_ERROR_LIMIT_PS / CLK_PERIOD_PS;
    localparam int LOCK_ERR_CYCLES  = 4;
    localparam int LOCK_GOOD_CYCLES = 32;
    localparam int TEST_EDGES       = 5;
    localparam int PARK_MAX_CYCLES  = 6;
    localparam int LOCK_CNT_W       = 8;
    localparam int WDOG_DIV_DEF     = 16;
    localparam int WDOG_TICKS_DEF   = 8;

    function automatic logic [1:0] plb_tri_val(plb_tri_t c);
        return c[1] ? 2'h2 : {1'b0, c[0]};
    endfunction : plb_tri_val

    function automatic logic [3:0] plb_pair_idx(plb_tri_t hi, plb_tri_t lo);
        return 4'(3 * plb_tri_val(hi) + plb_tri_val(lo));
    endfunction : plb_pair_idx

    function automatic logic [3:0] plb_div_ratio(logic [3:0] idx);
        case (idx)
            4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5: return idx + 4'h1;
            4'h6:    return 4'h8;
            4'h7:    return 4'hA;
            default: return 4'hC;
        endcase
    endfunction : plb_div_ratio

endpackage : plb_pkg

// file: plb_skew_path.sv
// Divider and skew delay line for one output group
// Assumes srcRise is a one-cycle pulse on the source clock rising edge
`timescale 1ns/100ps
module plb_skew_path (
    // Clock and reset
    input  wire logic                      clk,
    input  wire logic                      reset_n,
    // Source
    input  wire logic                      srcLevel,
    input  wire logic                      srcRise,
    input  wire logic                      hold,
    // Selections
    input  wire logic [3:0]                ratio,
    input  wire logic [3:0]                preset,
    input  wire logic [plb_pkg::TAP_W-1:0] tap,
    // Output
    output logic                           pathClk
);
    import plb_pkg::*;

    logic [3:0]           divCnt_r;
    logic [SKEW_TAPS-1:0] line_r;
    logic                 divClk;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            divCnt_r <= '0;
        end else if (hold) begin
            divCnt_r <= preset;
        end else if (srcRise) begin
            divCnt_r <= (divCnt_r >= ratio - 4'h1) ? 4'h0 : divCnt_r + 4'h1;
        end
    end

    assign divClk = (ratio == 4'h1) ? srcLevel : (divCnt_r < ((ratio + 4'h1) >> 1));

    // One tap is one clk cycle of delay
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            line_r  <= '0;
            pathClk <= 1'b0;
        end else if (hold) begin
            line_r  <= '0;
            pathClk <= 1'b0;
        end else begin
            line_r  <= {line_r[SKEW_TAPS-2:0], divClk};
            pathClk <= line_r[tap];
        end
    end

    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);

    held_state_a: assert property (hold ##1 hold |-> divCnt_r == $past(preset) && !pathClk)
        else $error("path not held");
endmodule : plb_skew_path

// file: tb.sv
// Self-checking bench for the PLL buffer control top
// Assumes the board model above; zero skew, divide by one, bank two follows pair A
`timescale 1ns/100ps
module tb;
    import plb_pkg::*;
    logic                  clk      = 1'b0;
    logic                  reset_n  = 1'b0;
    plb_tri_t              mode     = TRI_HIGH;
    logic [1:0]            bankDis  = 2'h0;
    logic [3:0]            fbOffset = 4'h0;
    logic                  fbOn     = 1'b1;
    logic                  refLevel, pllLevel, fbLevel, fbOut, lock, hiFb, loFb;
    plb_pins_t             pins;
    logic [BANK_ONE_W-1:0] oneQ, oneOe_n, hiOne, loOne;
    logic [BANK_TWO_W-1:0] twoQ, twoOe_n, hiTwo, loTwo;
    logic                  watch    = 1'b0;
    int                    hiLen    = 0;
    int                    bad_count = 0;
    int                    cmp_count = 0;

    always #2.5 clk = ~clk;

    // Bank two selects mid/low, so it follows pair A
    assign pins = '{mode, bankDis, refLevel, pllLevel, fbLevel, {4{TRI_MID}},
                    {TRI_MID, TRI_LOW}, TRI_MID, 12'h000, TRI_HIGH};

    plb_board_model board_u (.clk(clk), .reset_n(reset_n), .fbOffset(fbOffset), .fbOn(fbOn),
                             .refLevel(refLevel), .pllLevel(pllLevel), .fbLevel(fbLevel));

    plb_clock_control #(.WDOG_DIV(2), .WDOG_TICKS(2)) dut_u (
        .clk(clk), .reset_n(reset_n), .pins(pins),
        .bankOneOutputs(oneQ), .bankOneOe_n(oneOe_n),
        .bankTwoOutputs(twoQ), .bankTwoOe_n(twoOe_n),
        .feedbackOutput(fbOut), .lock(lock));

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic give_verdict();
        $display("Counts: %0d compares, %0d mismatches", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : give_verdict

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick

    task automatic observe(input int n);
        hiOne = '0;
        loOne = '1;
        hiTwo = '0;
        loTwo = '1;
        hiFb  = 1'b0;
        loFb  = 1'b1;
        repeat (n) begin
            tick(1);
            hiFb  |= fbOut;
            loFb  &= fbOut;
            hiOne |= oneQ;
            loOne &= oneQ;
            hiTwo |= twoQ;
            loTwo &= twoQ;
        end
    endtask : observe

    task automatic wait_lock(input logic v, input int maxCyc);
        int n;
        n = 0;
        while (lock !== v && n < maxCyc) begin
            tick(1);
            n++;
        end
        check(8'(lock), 8'(v));
    endtask : wait_lock

    // While watch is set, every finished high pulse on bank two bit 0 must be a whole half period
    always @(negedge clk) begin
        if (twoQ[0] === 1'b1) hiLen <= hiLen + 1;
        else begin
            if (watch && hiLen != 0) check(8'(hiLen >= 8), 8'h01);
            hiLen <= 0;
        end
    end

    initial begin
        repeat (20000) @(posedge clk);
        bad_count++;
        give_verdict();
    end

    initial begin
        repeat (8) @(posedge clk);
        reset_n <= 1'b1;
        tick(1);
        check(8'(lock), 8'h00);
        check(8'(oneQ), 8'h00);
        tick(480);
        check(8'(lock), 8'h00);
        wait_lock(1'b1, 300);
        $display("test lock_acquire done");
        // Mode held static while disabling one bank
        @(posedge clk) bankDis <= 2'b01;
        tick(3);
        check(8'(oneOe_n), 8'h0F);
        check(8'(twoOe_n), 8'h00);
        observe(32);
        check(8'(hiTwo), 8'h3F);
        check(8'(loTwo), 8'h00);
        @(posedge clk) bankDis <= 2'b00;
        mode <= TRI_LOW;
        tick(8);
        @(posedge clk) bankDis <= 2'b10;
        watch <= 1'b1;
        tick(6 * 16 + 4);
        observe(32);
        check(8'(hiTwo), 8'h00);
        check(8'(twoOe_n), 8'h00);
        check(8'(hiOne), 8'h0F);
        @(posedge clk) bankDis <= 2'b00;
        observe(40);
        check(8'(hiTwo), 8'h3F);
        watch <= 1'b0;
        $display("test disable done");
        @(posedge clk) fbOffset <= 4'h8;
        tick(2 * 16);
        check(8'(lock), 8'h01);
        wait_lock(1'b0, 4 * 16);
        @(posedge clk) fbOffset <= 4'h0;
        wait_lock(1'b1, 700);
        @(posedge clk) fbOn <= 1'b0;
        wait_lock(1'b0, 150);
        @(posedge clk) fbOn <= 1'b1;
        $display("test lock_loss done");
        @(posedge clk) mode <= TRI_MID;
        bankDis <= 2'b01;
        tick(3);
        check(8'(oneOe_n), 8'h00);
        observe(32);
        check(8'(hiOne), 8'h0F);
        check(8'(loOne), 8'h00);
        check(8'({hiFb, loFb}), 8'h02);
        @(posedge clk) bankDis <= 2'b10;
        tick(3);
        check(8'(oneOe_n), 8'h0F);
        check(8'(twoOe_n), 8'h3F);
        tick(8 * 16);
        observe(32);
        check(8'(hiOne | hiTwo), 8'h00);
        check(8'(hiFb), 8'h00);
        check(8'(twoOe_n), 8'h3F);
        @(posedge clk) bankDis <= 2'b00;
        tick(8);
        check(8'(oneOe_n), 8'h00);
        observe(48);
        check(8'(hiOne), 8'h0F);
        $display("test factory done");
        give_verdict();
    end
endmodule : tb
